// ===== sdram_bank_command_fsm.sv
// module: per-bank and device-wide command state machine of a four-bank sdram
// Function
// - chip select high: ignore, ops continue
// - nop keeps ongoing operations running
// - activate opens row in idle bank
// - refresh and mode load need all idle
// - precharge to idle bank is nop
// - active/read/write banks accept read, write
// - read burst: read restarts, precharge truncates
// - write burst: write restarts, precharge truncates
// - burst terminate, or deepest sleep when low
// - decode only when clock enable high twice
// - row active after delay, no burst
// - precharging until precharge time, then idle
// - activating until access delay, then active
// - auto precharge access busy until precharge done
// - refresh: only nops until refresh time
// - mode load: only nops until delay
// - precharge all: idle after precharge time
// - idle bank n lets others act
// - busy bank n lets others act
// - address bit ten selects precharge all
// - read cuts other read after latency
// - interrupted auto precharge bank starts precharging
`timescale 1ns/1ps

module sdram_bank_command_fsm #(
  parameter int unsigned RP_CYCLES  = sdram_bank_pkg::RP_CYC,
  parameter int unsigned RCD_CYCLES = sdram_bank_pkg::RCD_CYC,
  parameter int unsigned RFC_CYCLES = sdram_bank_pkg::RFC_CYC,
  parameter int unsigned MRD_CYCLES = sdram_bank_pkg::T_MRD_CYC,
  parameter int unsigned XSR_CYCLES = sdram_bank_pkg::XSR_CYC,
  parameter int unsigned BURST      = sdram_bank_pkg::BURST_LEN,
  parameter int unsigned CL         = sdram_bank_pkg::CAS_LAT
) (
  // clock and reset
  input  wire logic                                  core_clk_i,
  input  wire logic                                  arst_n_i,
  // command pins from the controller, on the link clock
  input  wire logic                                  link_clk_i,
  input  wire logic                                  cs_n_i,
  input  wire logic                                  ras_n_i,
  input  wire logic                                  cas_n_i,
  input  wire logic                                  we_n_i,
  input  wire logic                                  cke_i,
  input  wire logic [sdram_bank_pkg::BANK_W-1:0]     ba_i,
  input  wire logic [sdram_bank_pkg::ADDR_W-1:0]     addr_i,
  // self refresh exit, starts the exit wait
  input  wire logic                                  sr_exit_i,
  // state view
  output logic      [4*sdram_bank_pkg::NUM_BANKS-1:0] bank_state_o,
  output logic      [1:0]                            dev_state_o,
  output logic                                       all_idle_o,
  output logic                                       cmd_valid_o,
  output logic      [2:0]                            cmd_code_o,
  output logic                                       burst_read_o,
  output logic                                       burst_write_o,
  output logic      [sdram_bank_pkg::BANK_W-1:0]     burst_bank_o,
  output logic      [sdram_bank_pkg::COL_W-1:0]      burst_col_o,
  output logic                                       read_cut_o,
  output logic                                       deepest_sleep_state_o,
  output logic                                       illegal_cmd_o
);

  localparam int unsigned NB = sdram_bank_pkg::NUM_BANKS;
  localparam int unsigned CW = sdram_bank_pkg::CNT_W;
  localparam logic [CW-1:0] RP_L  = CW'(RP_CYCLES);
  localparam logic [CW-1:0] RCD_L = CW'(RCD_CYCLES);
  localparam logic [CW-1:0] RFC_L = CW'(RFC_CYCLES);
  localparam logic [CW-1:0] MRD_L = CW'(MRD_CYCLES);
  localparam logic [CW-1:0] XSR_L = CW'(XSR_CYCLES);
  localparam logic [CW-1:0] BL_L  = CW'(BURST);
  localparam logic [CW-1:0] CL_L  = CW'(CL);
  localparam logic [CW-1:0] ONE   = CW'(1);
  localparam logic [CW-1:0] ZERO  = '0;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers: the pins belong to the link clock domain

  // two stages for every pin and the link clock itself
  sdram_bank_pkg::cmd_bus_t pins_s1_r;                 // first stage, read by second only
  sdram_bank_pkg::cmd_bus_t pins_s2_r;                 // stable copy
  logic [1:0]               lclk_sync_r;               // link clock, two stages
  logic                     lclk_prev_r;               // for edge detection
  logic [1:0]               srx_sync_r;                // self refresh exit level
  logic                     srx_prev_r;
  sdram_bank_pkg::cmd_bus_t pins_now;

  assign pins_now = '{cs_n: cs_n_i, ras_n: ras_n_i, cas_n: cas_n_i, we_n: we_n_i,
                      cke: cke_i, ba: ba_i, addr: addr_i};

  // sampling the pins: at 320 ns link period there are eight core clocks per link clock,
  // so the pins are long settled when the delayed edge is seen
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pins_s1_r   <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b0, default: '0};
      pins_s2_r   <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b0, default: '0};
      lclk_sync_r <= 2'h0;
      lclk_prev_r <= 1'b0;
      srx_sync_r  <= 2'h0;
      srx_prev_r  <= 1'b0;
    end
    else
    begin
      pins_s1_r   <= pins_now;
      pins_s2_r   <= pins_s1_r;
      lclk_sync_r <= {lclk_sync_r[0], link_clk_i};
      lclk_prev_r <= lclk_sync_r[1];
      srx_sync_r  <= {srx_sync_r[0], sr_exit_i};
      srx_prev_r  <= srx_sync_r[1];
    end
  end

  // one pulse per rising link clock edge: the device's command edge
  wire edge_en = lclk_sync_r[1] & ~lclk_prev_r;
  wire srx_rise = srx_sync_r[1] & ~srx_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  logic cke_prev_r;                                     // clock enable at previous edge
  wire  [2:0] cmd  = {pins_s2_r.ras_n, pins_s2_r.cas_n, pins_s2_r.we_n};
  wire  sel        = ~pins_s2_r.cs_n;                  // inhibit when high
  wire  cke_ok     = cke_prev_r & pins_s2_r.cke;       // high on both edges
  wire  ap_bit     = pins_s2_r.addr[sdram_bank_pkg::AP_BIT];
  wire  [sdram_bank_pkg::BANK_W-1:0] cba = pins_s2_r.ba;

  sdram_bank_pkg::dev_state_t dev_r;                    // device-wide state
  logic [CW-1:0]              dev_cnt_r;                // global down-counter

  // decode is live only in normal state with clock enable held
  wire  live     = edge_en & sel & cke_ok & (dev_r == sdram_bank_pkg::DV_NORMAL);
  wire  c_act    = live & (cmd == sdram_bank_pkg::CMD_ACT);
  wire  c_rd     = live & (cmd == sdram_bank_pkg::CMD_RD);
  wire  c_wr     = live & (cmd == sdram_bank_pkg::CMD_WR);
  wire  c_bst    = live & (cmd == sdram_bank_pkg::CMD_BST);
  wire  c_pre    = live & (cmd == sdram_bank_pkg::CMD_PRE);
  wire  c_ref    = live & (cmd == sdram_bank_pkg::CMD_REF);
  wire  c_mrl    = live & (cmd == sdram_bank_pkg::CMD_MRL);
  wire  c_pall   = c_pre & ap_bit;                           // all banks, bank bits ignored
  // same encoding with clock enable falling: deep sleep entry, not a terminate
  wire  c_dsleep = edge_en & sel & cke_prev_r & ~pins_s2_r.cke
                 & (cmd == sdram_bank_pkg::CMD_BST) & all_idle_o;

  ////////////////////////////////////////////////////////////////////////////
  // per-bank state machines

  sdram_bank_pkg::bank_state_t bst_r [NB];              // bank states
  logic [CW-1:0]               bcnt_r [NB];             // per-bank delay / burst counters
  logic [NB-1:0]               bidle;
  logic [NB-1:0]               bbad;                    // command refused by that bank's state

  // the bank most recently bursting, for terminate and interrupts
  logic [sdram_bank_pkg::BANK_W-1:0] last_bank_r;
  wire  any_burst = c_rd | c_wr;

  genvar g;
  generate
    for (g = 0; g < NB; g++)
    begin : g_bank
      wire hit  = (cba == sdram_bank_pkg::BANK_W'(g));
      wire to_me = hit;
      sdram_bank_pkg::bank_state_t s;
      assign s = bst_r[g];
      wire open_row = (s == sdram_bank_pkg::BK_ACTIVE) | (s == sdram_bank_pkg::BK_READ)
                    | (s == sdram_bank_pkg::BK_WRITE);
      wire busy_ap  = (s == sdram_bank_pkg::BK_READ_AP) | (s == sdram_bank_pkg::BK_WRIT_AP);
      // another bank's burst interrupts this auto precharge burst
      wire ap_cut   = busy_ap & any_burst & ~to_me;
      // precharge of this bank, single or all; idle bank ignores it
      wire pre_me   = (c_pall | (c_pre & to_me)) & open_row;
      // terminate applies only to the bank that bursts last
      wire bst_me   = c_bst & (last_bank_r == sdram_bank_pkg::BANK_W'(g))
                    & ((s == sdram_bank_pkg::BK_READ) | (s == sdram_bank_pkg::BK_WRITE));

      assign bidle[g] = (s == sdram_bank_pkg::BK_IDLE);
      // busy states refuse commands to this bank
      assign bbad[g]  = to_me & (c_act | c_rd | c_wr | (c_pre & ~ap_bit))
                      & ((s == sdram_bank_pkg::BK_ACTG) | (s == sdram_bank_pkg::BK_PRECH)
                         | (s == sdram_bank_pkg::BK_AP_PRE) | busy_ap
                         | ((c_rd | c_wr) & ~open_row) | (c_act & ~bidle[g]));

      // bank state update; commands to other banks leave this one alone, except a burst that cuts its auto precharge burst
      always_ff @(posedge core_clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          bst_r[g]  <= sdram_bank_pkg::BK_IDLE;
          bcnt_r[g] <= ZERO;
        end
        else if (dev_r == sdram_bank_pkg::DV_REFRESH || dev_r == sdram_bank_pkg::DV_MODE)
        begin
          bst_r[g]  <= sdram_bank_pkg::BK_IDLE;               // all idle during global ops
          bcnt_r[g] <= ZERO;
        end
        else if (pre_me)
        begin
          bst_r[g]  <= sdram_bank_pkg::BK_PRECH;
          bcnt_r[g] <= RP_L;
        end
        else if (ap_cut)
        begin
          bst_r[g]  <= sdram_bank_pkg::BK_AP_PRE;
          bcnt_r[g] <= RP_L;
        end
        else if (to_me & c_act & bidle[g])
        begin
          bst_r[g]  <= sdram_bank_pkg::BK_ACTG;
          bcnt_r[g] <= RCD_L;
        end
        else if (to_me & any_burst & open_row)
        begin
          // read/write restarts a burst, with or without auto precharge
          unique case ({c_wr, ap_bit})
            2'h0:    bst_r[g] <= sdram_bank_pkg::BK_READ;
            2'h1:    bst_r[g] <= sdram_bank_pkg::BK_READ_AP;
            2'h2:    bst_r[g] <= sdram_bank_pkg::BK_WRITE;
            default: bst_r[g] <= sdram_bank_pkg::BK_WRIT_AP;
          endcase
          bcnt_r[g] <= BL_L;
        end
        else if (bst_me)
        begin
          bst_r[g]  <= sdram_bank_pkg::BK_ACTIVE;             // burst cut short
          bcnt_r[g] <= ZERO;
        end
        else if (edge_en && bcnt_r[g] != ZERO)
        begin
          bcnt_r[g] <= bcnt_r[g] - ONE;                       // counts only on command edges
        end
        else if (edge_en)
        begin
          // counter expired: timed transitions
          unique case (s)
            sdram_bank_pkg::BK_ACTG:   bst_r[g] <= sdram_bank_pkg::BK_ACTIVE;
            sdram_bank_pkg::BK_READ,
            sdram_bank_pkg::BK_WRITE:  bst_r[g] <= sdram_bank_pkg::BK_ACTIVE;  // burst done
            sdram_bank_pkg::BK_READ_AP,
            sdram_bank_pkg::BK_WRIT_AP:
            begin
              bst_r[g]  <= sdram_bank_pkg::BK_AP_PRE;
              bcnt_r[g] <= RP_L;
            end
            sdram_bank_pkg::BK_PRECH,
            sdram_bank_pkg::BK_AP_PRE: bst_r[g] <= sdram_bank_pkg::BK_IDLE;
            default:                   bst_r[g] <= s;   // idle/active hold
          endcase
        end
      end

      assign bank_state_o[4*g +: 4] = s;
    end
  endgenerate

  assign all_idle_o = &bidle;

  ////////////////////////////////////////////////////////////////////////////
  // device-wide state: refresh, mode load, self refresh exit

  // global ops only when every bank idle
  wire glob_ok = all_idle_o;

  // clock enable history and device state update
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cke_prev_r <= 1'b0;
      dev_r      <= sdram_bank_pkg::DV_NORMAL;
      dev_cnt_r  <= ZERO;
    end
    else
    begin
      if (edge_en)
      begin
        cke_prev_r <= pins_s2_r.cke;
      end
      if (srx_rise)
      begin
        dev_r     <= sdram_bank_pkg::DV_XSR;                  // wait exit time
        dev_cnt_r <= XSR_L;
      end
      else if (c_ref & glob_ok)
      begin
        dev_r     <= sdram_bank_pkg::DV_REFRESH;
        dev_cnt_r <= RFC_L;
      end
      else if (c_mrl & glob_ok)
      begin
        dev_r     <= sdram_bank_pkg::DV_MODE;
        dev_cnt_r <= MRD_L;
      end
      else if (edge_en && dev_r != sdram_bank_pkg::DV_NORMAL)
      begin
        if (dev_cnt_r > ONE)
        begin
          dev_cnt_r <= dev_cnt_r - ONE;
        end
        else
        begin
          dev_r     <= sdram_bank_pkg::DV_NORMAL;             // back to normal; banks all idle only after refresh or mode load
          dev_cnt_r <= ZERO;
        end
      end
    end
  end

  assign dev_state_o = dev_r;

  ////////////////////////////////////////////////////////////////////////////
  // burst report and read interrupt timing

  logic [CW-1:0] cut_cnt_r;                             // counts latency to cut old read
  wire  rd_over_rd = c_rd & (cba != last_bank_r)
                   & (bst_r[last_bank_r] == sdram_bank_pkg::BK_READ);

  // registered outputs for the data path
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cmd_valid_o           <= 1'b0;
      cmd_code_o            <= sdram_bank_pkg::CMD_NOP;
      burst_read_o          <= 1'b0;
      burst_write_o         <= 1'b0;
      burst_bank_o          <= '0;
      burst_col_o           <= '0;
      last_bank_r           <= '0;
      cut_cnt_r             <= ZERO;
      read_cut_o            <= 1'b0;
      deepest_sleep_state_o <= 1'b0;
      illegal_cmd_o         <= 1'b0;
    end
    else
    begin
      cmd_valid_o   <= live;
      cmd_code_o    <= live ? cmd : sdram_bank_pkg::CMD_NOP;
      burst_read_o  <= c_rd & ~|bbad;
      burst_write_o <= c_wr & ~|bbad;
      illegal_cmd_o <= |bbad | ((c_ref | c_mrl) & ~glob_ok);   // refused, not acted on
      if (any_burst & ~|bbad)
      begin
        burst_bank_o <= cba;
        burst_col_o  <= pins_s2_r.addr[sdram_bank_pkg::COL_W-1:0];
        last_bank_r  <= cba;
      end
      // old read's data cut one latency after the new read
      if (rd_over_rd)
      begin
        cut_cnt_r <= CL_L;
      end
      else if (edge_en && cut_cnt_r != ZERO)
      begin
        cut_cnt_r <= cut_cnt_r - ONE;
      end
      read_cut_o <= edge_en & (cut_cnt_r == ONE);
      // deep sleep held until clock enable returns high
      if (c_dsleep)
      begin
        deepest_sleep_state_o <= 1'b1;
      end
      else if (edge_en & pins_s2_r.cke)
      begin
        deepest_sleep_state_o <= 1'b0;
      end
    end
  end

endmodule // sdram_bank_command_fsm

// ===== sdram_bank_command_fsm_monitor.sv
// checker: concurrent assertions on the ports of the bank command state machine
`timescale 1ns/1ps

module sdram_bank_command_fsm_monitor (
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        arst_n_i,
  // state view of the design
  input wire logic [15:0] bank_state_o,
  input wire logic [1:0]  dev_state_o,
  input wire logic        all_idle_o,
  input wire logic        cmd_valid_o,
  input wire logic [2:0]  cmd_code_o,
  input wire logic        burst_read_o,
  input wire logic [1:0]  burst_bank_o,
  input wire logic        read_cut_o,
  input wire logic        deepest_sleep_state_o,
  input wire logic        illegal_cmd_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  // true when any bank holds the given state
  function automatic logic any_st(input logic [15:0] v, input logic [3:0] s);
    return (v[3:0] == s) || (v[7:4] == s) || (v[11:8] == s) || (v[15:12] == s);
  endfunction

  // a command that was taken and not refused
  wire logic taken = cmd_valid_o && !illegal_cmd_o;

  ////////////////////////////////////////////////////////////////////////
  AST_ALL_IDLE: assert property (all_idle_o == (bank_state_o == 16'h0000))
    else $error("all idle flag disagrees with bank states");
  AST_IDLE_CODE: assert property (!cmd_valid_o |-> cmd_code_o == sdram_bank_pkg::CMD_NOP)
    else $error("command code shown without a taken command");
  AST_ACT_OPENS: assert property (taken && cmd_code_o == sdram_bank_pkg::CMD_ACT |-> any_st(bank_state_o, 4'h1))
    else $error("activate taken but no bank activating");
  AST_RD_CODE: assert property (burst_read_o |-> cmd_valid_o && cmd_code_o == sdram_bank_pkg::CMD_RD)
    else $error("read burst without read command");
  AST_RD_BANK: assert property (burst_read_o |-> bank_state_o[4*burst_bank_o +: 4] inside {4'h2, 4'h7})
    else $error("read burst bank not in a read state");
  AST_REF_DEV: assert property (taken && cmd_code_o == sdram_bank_pkg::CMD_REF |-> dev_state_o == 2'h1)
    else $error("refresh taken but device not refreshing");
  AST_MRL_DEV: assert property (taken && cmd_code_o == sdram_bank_pkg::CMD_MRL |-> dev_state_o == 2'h3)
    else $error("mode load taken but device not in mode access");
  AST_BUSY_DEV: assert property ($past(dev_state_o) != 2'h0 |-> !cmd_valid_o)
    else $error("command taken during device-wide operation");
  AST_SLEEP_IDLE: assert property ($rose(deepest_sleep_state_o) |-> all_idle_o)
    else $error("deepest sleep entered with banks open");

  // main scenarios seen
  COV_READ: cover property (burst_read_o);
  COV_CUT: cover property (read_cut_o);
  COV_REFUSED: cover property (illegal_cmd_o);
endmodule // sdram_bank_command_fsm_monitor

bind sdram_bank_command_fsm sdram_bank_command_fsm_monitor mon (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .bank_state_o(bank_state_o), .dev_state_o(dev_state_o),
  .all_idle_o(all_idle_o), .cmd_valid_o(cmd_valid_o), .cmd_code_o(cmd_code_o), .burst_read_o(burst_read_o),
  .burst_bank_o(burst_bank_o), .read_cut_o(read_cut_o), .deepest_sleep_state_o(deepest_sleep_state_o),
  .illegal_cmd_o(illegal_cmd_o));

// ===== sdram_bank_command_fsm_tb.sv
// testbench: command sequences through the link pins, with state checks
`timescale 1ns/1ps

module sdram_bank_command_fsm_tb;
  // short delay counts keep the run brief
  localparam int unsigned RP = 2, RCD = 2, RFC = 3, MRD = 2, BRST = 4, CLV = 3;
  // short names for the command encodings
  localparam logic [2:0] NOP = sdram_bank_pkg::CMD_NOP, ACT = sdram_bank_pkg::CMD_ACT, RD = sdram_bank_pkg::CMD_RD,
    WR = sdram_bank_pkg::CMD_WR, PRE = sdram_bank_pkg::CMD_PRE, REF = sdram_bank_pkg::CMD_REF,
    MRL = sdram_bank_pkg::CMD_MRL, BST = sdram_bank_pkg::CMD_BST;
  logic                     clk;
  logic                     arst_n;
  logic                     link_clk;
  sdram_bank_pkg::cmd_bus_t pins;
  logic [15:0]              bank_st;
  logic [1:0]               dev_st, bb;
  logic [2:0]               code;
  logic [9:0]               bc;
  logic                     all_idle, valid, rd_p, wr_p, cut_p, sleep, ill;
  int                       fails = 0, comparisons = 0, n_rd = 0, n_wr = 0, n_cut = 0, n_ill = 0;

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // pulse counters, since pulses stand only one core cycle
  always @(posedge clk)
  begin
    n_rd += int'(rd_p === 1'b1);
    n_wr += int'(wr_p === 1'b1);
    n_cut += int'(cut_p === 1'b1);
    n_ill += int'(ill === 1'b1);
  end

  sdram_bank_command_fsm #(.RP_CYCLES(RP), .RCD_CYCLES(RCD), .RFC_CYCLES(RFC), .MRD_CYCLES(MRD),
    .XSR_CYCLES(3), .BURST(BRST), .CL(CLV)) DUT (
    .core_clk_i(clk), .arst_n_i(arst_n), .link_clk_i(link_clk), .cs_n_i(pins.cs_n), .ras_n_i(pins.ras_n),
    .cas_n_i(pins.cas_n), .we_n_i(pins.we_n), .cke_i(pins.cke), .ba_i(pins.ba), .addr_i(pins.addr),
    .sr_exit_i(1'b0), .bank_state_o(bank_st), .dev_state_o(dev_st), .all_idle_o(all_idle),
    .cmd_valid_o(valid), .cmd_code_o(code), .burst_read_o(rd_p), .burst_write_o(wr_p), .burst_bank_o(bb),
    .burst_col_o(bc), .read_cut_o(cut_p), .deepest_sleep_state_o(sleep), .illegal_cmd_o(ill));

  sdram_ctl_model ctl (.core_clk_i(clk), .link_clk_o(link_clk), .pins_o(pins));

  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one bank nibble against its expected state
  task automatic chk_bank(input int b, input sdram_bank_pkg::bank_state_t s);
    chk_val(16'(bank_st[4*b +: 4]), 16'(s));
  endtask

  task automatic send(input logic cs_n, input logic [2:0] op, input logic [1:0] ba, input logic [12:0] a,
                      input logic cke = 1'b1);
    ctl.issue('{cs_n: cs_n, ras_n: op[2], cas_n: op[1], we_n: op[0], cke: cke, ba: ba, addr: a});
  endtask

  task automatic cmd(input logic [2:0] op, input logic [1:0] ba, input logic [12:0] a);
    send(1'b0, op, ba, a);
  endtask

  task automatic nop(input int n);
    repeat (n) cmd(NOP, 2'h0, 13'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // activate, deselected command, reads, precharge in mid-burst
  task automatic t_basic();
    int r0;
    r0 = n_rd;
    cmd(ACT, 2'h1, 13'h0055);
    chk_bank(1, sdram_bank_pkg::BK_ACTG);
    send(1'b1, ACT, 2'h2, 13'h0000);
    chk_bank(2, sdram_bank_pkg::BK_IDLE);
    nop(RCD);
    chk_bank(1, sdram_bank_pkg::BK_ACTIVE);
    cmd(RD, 2'h1, 13'h0015);
    chk_bank(1, sdram_bank_pkg::BK_READ);
    chk_val(16'(bb), 16'h0001);
    chk_val(16'(bc), 16'h0015);
    cmd(RD, 2'h1, 13'h0020);
    chk_val(16'(n_rd - r0), 16'h0002);
    chk_val(16'(bc), 16'h0020);
    cmd(PRE, 2'h1, 13'h0000);
    chk_bank(1, sdram_bank_pkg::BK_PRECH);
    nop(RP + 1);
    chk_bank(1, sdram_bank_pkg::BK_IDLE);
  endtask

  // refused refresh, idle precharge, precharge all, refresh and mode load
  task automatic t_global();
    int i0;
    i0 = n_ill;
    cmd(ACT, 2'h0, 13'h0000);
    cmd(REF, 2'h0, 13'h0000);
    chk_val(16'(dev_st), 16'(sdram_bank_pkg::DV_NORMAL));
    chk_val(16'(n_ill - i0), 16'h0001);
    nop(RCD);
    cmd(PRE, 2'h2, 13'h0000);
    chk_bank(2, sdram_bank_pkg::BK_IDLE);
    chk_val(16'(n_ill - i0), 16'h0001);
    cmd(PRE, 2'h3, 13'h0400);
    chk_bank(0, sdram_bank_pkg::BK_PRECH);
    nop(RP + 1);
    chk_val(16'(all_idle), 16'h0001);
    cmd(REF, 2'h0, 13'h0000);
    chk_val(16'(dev_st), 16'(sdram_bank_pkg::DV_REFRESH));
    nop(RFC + 1);
    chk_val(16'(dev_st), 16'(sdram_bank_pkg::DV_NORMAL));
    cmd(MRL, 2'h0, 13'h0023);
    chk_val(16'(dev_st), 16'(sdram_bank_pkg::DV_MODE));
    nop(MRD + 1);
    chk_val(16'(dev_st), 16'(sdram_bank_pkg::DV_NORMAL));
  endtask

  // two banks: cross-bank activate, read cut, interrupted auto precharge, refusals
  task automatic t_banks();
    int c0, i0;
    cmd(ACT, 2'h0, 13'h0000);
    cmd(ACT, 2'h2, 13'h0000);
    chk_bank(2, sdram_bank_pkg::BK_ACTG);
    nop(RCD + 1);
    c0 = n_cut;
    cmd(RD, 2'h0, 13'h0008);
    cmd(RD, 2'h2, 13'h0009);
    nop(CLV);
    chk_val(16'(n_cut - c0), 16'h0001);
    cmd(WR, 2'h0, 13'h0410);
    chk_bank(0, sdram_bank_pkg::BK_WRIT_AP);
    cmd(RD, 2'h2, 13'h0004);
    chk_bank(0, sdram_bank_pkg::BK_AP_PRE);
    i0 = n_ill;
    cmd(ACT, 2'h0, 13'h0000);
    cmd(WR, 2'h3, 13'h0000);
    chk_val(16'(n_ill - i0), 16'h0002);
    nop(8);
    cmd(PRE, 2'h0, 13'h0400);
    nop(RP + 1);
  endtask

  // write bursts, precharge and terminate in mid-write, deepest sleep, clock enable history
  task automatic t_term();
    int w0;
    w0 = n_wr;
    cmd(ACT, 2'h2, 13'h0000);
    nop(RCD + 1);
    cmd(WR, 2'h2, 13'h0001);
    cmd(WR, 2'h2, 13'h0002);
    chk_val(16'(n_wr - w0), 16'h0002);
    chk_bank(2, sdram_bank_pkg::BK_WRITE);
    cmd(PRE, 2'h2, 13'h0000);
    chk_bank(2, sdram_bank_pkg::BK_PRECH);
    nop(RP + 1);
    cmd(ACT, 2'h2, 13'h0000);
    nop(RCD + 1);
    cmd(WR, 2'h2, 13'h0003);
    cmd(BST, 2'h2, 13'h0000);
    chk_bank(2, sdram_bank_pkg::BK_ACTIVE);
    cmd(PRE, 2'h2, 13'h0000);
    nop(RP + 1);
    send(1'b0, BST, 2'h0, 13'h0000, 1'b0);
    chk_val(16'(sleep), 16'h0001);
    send(1'b0, ACT, 2'h1, 13'h0000, 1'b1);
    chk_bank(1, sdram_bank_pkg::BK_IDLE);
    chk_val(16'(sleep), 16'h0000);
    nop(1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end

  // reset, clock enable history, then the scenarios
  initial
  begin
    arst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk);
    nop(2);
    t_basic();
    t_global();
    t_banks();
    t_term();
    results();
  end
endmodule // sdram_bank_command_fsm_tb

// ===== sdram_bank_pkg.sv
// package: constants, types and command encodings for the sdram bank command state machine
package sdram_bank_pkg;

  // bank count and bank address width
  localparam int unsigned NUM_BANKS   = 4;
  localparam int unsigned BANK_W      = 2;
  localparam int unsigned ADDR_W      = 13;
  localparam int unsigned COL_W       = 10;
  localparam int unsigned AP_BIT      = 10;          // address bit 10: auto precharge / all banks

  // clock rate, used to turn times into cycles
  localparam int unsigned CLK_MHZ     = 25;

  // timing figures in nanoseconds, plain defaults
  localparam int unsigned T_RP_NS     = 18;
  localparam int unsigned T_RCD_NS    = 18;
  localparam int unsigned T_RFC_NS    = 72;
  localparam int unsigned T_XSR_NS    = 112;
  localparam int unsigned T_MRD_CYC   = 2;           // given in clock cycles
  localparam int unsigned BURST_LEN   = 4;
  localparam int unsigned CAS_LAT     = 3;

  // least times round up to whole cycles, never below one
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned RP_CYC      = ns_to_cyc(T_RP_NS);
  localparam int unsigned RCD_CYC     = ns_to_cyc(T_RCD_NS);
  localparam int unsigned RFC_CYC     = ns_to_cyc(T_RFC_NS);
  localparam int unsigned XSR_CYC     = ns_to_cyc(T_XSR_NS);

  // counter width for all delay counters
  localparam int unsigned CNT_W       = 8;

  // command decode {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] CMD_NOP      = 3'h7;
  localparam logic [2:0] CMD_ACT      = 3'h3;
  localparam logic [2:0] CMD_RD       = 3'h5;
  localparam logic [2:0] CMD_WR       = 3'h4;
  localparam logic [2:0] CMD_BST      = 3'h6;
  localparam logic [2:0] CMD_PRE      = 3'h2;
  localparam logic [2:0] CMD_REF      = 3'h1;
  localparam logic [2:0] CMD_MRL      = 3'h0;

  // per-bank state, gray along idle -> activating -> active -> read -> write
  typedef enum logic [3:0] {
    BK_IDLE    = 4'h0,
    BK_ACTG    = 4'h1,
    BK_ACTIVE  = 4'h3,
    BK_READ    = 4'h2,
    BK_WRITE   = 4'h6,
    BK_READ_AP = 4'h7,
    BK_WRIT_AP = 4'h5,
    BK_PRECH   = 4'h4,
    BK_AP_PRE  = 4'hC
  } bank_state_t;

  // device-wide state
  typedef enum logic [1:0] {
    DV_NORMAL  = 2'h0,
    DV_REFRESH = 2'h1,
    DV_MODE    = 2'h3,
    DV_XSR     = 2'h2
  } dev_state_t;

  // command pins, as sampled
  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              cke;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } cmd_bus_t;

endpackage

// ===== sdram_ctl_model.sv
// partner: memory controller model issuing one command per link clock cycle
`timescale 1ns/1ps

module sdram_ctl_model (
  // core clock paces the link clock
  input  wire logic                 core_clk_i,
  // link clock and command pins toward the device
  output logic                      link_clk_o,
  output sdram_bank_pkg::cmd_bus_t  pins_o
);
  // start deselected, link clock low
  initial
  begin
    link_clk_o = 1'b0;
    pins_o = '1;
  end

  // one 320 ns link cycle; the clock stands still between commands
  // the caller sequences the commands, refused ones included, and waits
  task automatic issue(input sdram_bank_pkg::cmd_bus_t c);
    @(posedge core_clk_i);
    #1 pins_o = c;
    @(posedge core_clk_i);
    #1 link_clk_o = 1'b1;
    repeat (4) @(posedge core_clk_i);
    #1 link_clk_o = 1'b0;
    // released pins show the inverse, not the last command
    pins_o = ~c;
    repeat (2) @(posedge core_clk_i);
    #2;
  endtask
endmodule // sdram_ctl_model
